// *** dv/io_read_instruction_core_model.sv ***
// Processor core model issuing I/O read and write instructions
`timescale 1ns/1ps
module io_read_instruction_core_model (
  input wire logic i_clk,
  input wire logic [7:0] i_acc_data,
  input wire logic i_acc_valid,
  output logic o_rd,
  output logic o_wr,
  output logic o_wx,
  output logic [7:0] o_operand,
  output logic [7:0] o_index,
  output logic [7:0] o_acc
);
  initial begin
    {o_rd, o_wr, o_wx} = 3'b000;
    {o_operand, o_index, o_acc} = 24'h00_0000;
  end
  // Read: one strobe cycle, answer sampled one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_rd = 1'b1;
    o_operand = a;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_operand = ~a;
    d = i_acc_data;
    v = i_acc_valid;
  endtask : rd
  // Write; caller keeps reserved bits zero
  task automatic wr(input bit idx, input logic [7:0] a, x, v);
    @(negedge i_clk);
    o_wr = !idx;
    o_wx = idx;
    o_operand = a;
    o_index = x;
    o_acc = v;
    @(negedge i_clk);
    {o_wr, o_wx} = 2'b00;
    o_operand = ~a;
    o_index = ~x;
    o_acc = ~v;
  endtask : wr
endmodule : io_read_instruction_core_model

// *** dv/tb_io_register_space_decoder.sv ***
// Self-checking bench of the I/O register space decoder
`timescale 1ns/1ps
module tb_io_register_space_decoder;
  logic i_clk, i_rstn, five, vclr, wdog, fba, av, rd, wr, wx, v;
  logic [7:0] vec, e3, e4, pe0, pe1, hen, ad, op, ix, acc, d, l0, l1;
  int error_cnt = 0, samples_checked = 0, vclr_n = 0, wdog_n = 0;
  logic [7:0] rw_a [23] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h15, 8'h16, 8'h1f, 8'h20, 8'h21, 8'h28, 8'h29, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
    8'h48, 8'h49};
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  io_read_instruction_io_space #(.TMR_DIV(4)) DUT (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_io_read_instruction(rd), .i_io_direct_write_instruction(wr),
    .i_io_indexed_write_instruction(wx), .i_operand(op), .i_index(ix), .i_acc(acc),
    .i_five_ep_mode(five), .i_irq_vector(vec), .o_acc_data(ad), .o_acc_valid(av),
    .o_vector_clear(vclr), .o_watchdog_restart(wdog), .o_faddr_b_active(fba),
    .o_ep3_mode(e3), .o_ep4_mode(e4), .o_p0_irq_en(pe0), .o_p1_irq_en(pe1), .o_hub_en(hen));
  io_read_instruction_core_model core (.i_clk(i_clk), .i_acc_data(ad), .i_acc_valid(av), .o_rd(rd),
    .o_wr(wr), .o_wx(wx), .o_operand(op), .o_index(ix), .o_acc(acc));
  always @(posedge i_clk) begin
    if (vclr === 1'b1) vclr_n++;
    if (wdog === 1'b1) wdog_n++;
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, e);
    core.rd(a, d, v);
    chk("acc_valid", 8'h01, {7'h00, v});
    chk("acc_data", e, d);
  endtask : rd_chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (50000) @(posedge i_clk);
    error_cnt++;
    close_out();
  end
  initial begin
    {i_rstn, five} = 2'b00;
    vec = 8'h00;
    repeat (8) @(negedge i_clk);
    i_rstn = 1'b1;
    core.rd(8'h24, l0, v);
    chk("tmr_lo_small", 8'h00, {7'h00, l0 >= 8'h08});
    rd_chk(8'h25, 8'h00);
    repeat (1100) @(negedge i_clk);
    rd_chk(8'h25, 8'h00);
    core.rd(8'h24, l1, v);
    chk("tmr_runs", 8'h01, {7'h00, l1 != l0});
    rd_chk(8'h25, 8'h01);
    $display("test timer done");
    foreach (rw_a[i]) rd_chk(rw_a[i], 8'h00);
    foreach (rw_a[i]) core.wr(1'b0, rw_a[i], 8'hff, rw_a[i] ^ 8'ha5);
    foreach (rw_a[i]) rd_chk(rw_a[i], rw_a[i] ^ 8'ha5);
    $display("test read write done");
    core.wr(1'b0, 8'h04, 8'h00, 8'h3c);
    core.wr(1'b0, 8'h05, 8'h00, 8'hc3);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h05, 8'h00);
    chk("p0_irq_en", 8'h3c, pe0);
    chk("p1_irq_en", 8'hc3, pe1);
    core.wr(1'b1, 8'h10, 8'h01, 8'h77);
    rd_chk(8'h11, 8'h77);
    core.wr(1'b1, 8'h00, 8'h49, 8'h0f);
    chk("hub_en", 8'h0f, hen);
    core.wr(1'b1, 8'hf0, 8'h20, 8'h66);
    rd_chk(8'h10, 8'h66);
    $display("test write modes done");
    core.wr(1'b0, 8'h25, 8'h00, 8'hff);
    core.wr(1'b0, 8'h23, 8'h00, 8'hff);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h25, 8'h01);
    rd_chk(8'h48, 8'h48 ^ 8'ha5);
    vec = 8'h1c;
    rd_chk(8'h23, 8'h1c);
    core.wr(1'b0, 8'h26, 8'h00, 8'h01);
    rd_chk(8'h26, 8'h00);
    chk("vector_clear_pulses", 8'h01, 8'(vclr_n));
    chk("watchdog_pulses", 8'h01, 8'(wdog_n));
    $display("test side effects done");
    chk("faddr_b_active", 8'h01, {7'h00, fba});
    chk("ep3_off", 8'h00, e3);
    five = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("faddr_b_idle", 8'h00, {7'h00, fba});
    chk("ep3_mode", 8'h42 ^ 8'ha5, e3);
    chk("ep4_mode", 8'h44 ^ 8'ha5, e4);
    $display("test five endpoint done");
    close_out();
  end
endmodule : tb_io_register_space_decoder

// *** verilog/io_read_instruction_defines.svh ***
// Register addresses, timer width and timing counts of the I/O register space
`ifndef IO_READ_INSTRUCTION_DEFINES_SVH
`define IO_READ_INSTRUCTION_DEFINES_SVH
`define IO_READ_INSTRUCTION_A_P0_DATA 8'h00
`define IO_READ_INSTRUCTION_A_P1_DATA 8'h01
`define IO_READ_INSTRUCTION_A_P0_IRQ_EN 8'h04
`define IO_READ_INSTRUCTION_A_P1_IRQ_EN 8'h05
`define IO_READ_INSTRUCTION_A_GPIO_CFG 8'h08
`define IO_READ_INSTRUCTION_A_SB_POS_CFG 8'h09
`define IO_READ_INSTRUCTION_A_FADDR_A 8'h10
`define IO_READ_INSTRUCTION_A_A_EP0_CNT 8'h11
`define IO_READ_INSTRUCTION_A_A_EP0_MODE 8'h12
`define IO_READ_INSTRUCTION_A_A_EP1_CNT 8'h13
`define IO_READ_INSTRUCTION_A_A_EP1_MODE 8'h14
`define IO_READ_INSTRUCTION_A_A_EP2_CNT 8'h15
`define IO_READ_INSTRUCTION_A_A_EP2_MODE 8'h16
`define IO_READ_INSTRUCTION_A_USB_STAT_CTL 8'h1f
`define IO_READ_INSTRUCTION_A_GLB_IRQ_EN 8'h20
`define IO_READ_INSTRUCTION_A_EP_IRQ_EN 8'h21
`define IO_READ_INSTRUCTION_A_IRQ_VECTOR 8'h23
`define IO_READ_INSTRUCTION_A_TMR_LO 8'h24
`define IO_READ_INSTRUCTION_A_TMR_HI 8'h25
`define IO_READ_INSTRUCTION_A_WDOG_CLR 8'h26
`define IO_READ_INSTRUCTION_A_SB_CTL_STAT 8'h28
`define IO_READ_INSTRUCTION_A_SB_DATA 8'h29
`define IO_READ_INSTRUCTION_A_FADDR_B 8'h40
`define IO_READ_INSTRUCTION_A_B_EP0_CNT 8'h41
`define IO_READ_INSTRUCTION_A_B_EP0_MODE 8'h42
`define IO_READ_INSTRUCTION_A_B_EP1_CNT 8'h43
`define IO_READ_INSTRUCTION_A_B_EP1_MODE 8'h44
`define IO_READ_INSTRUCTION_A_HUB_CONN 8'h48
`define IO_READ_INSTRUCTION_A_HUB_EN 8'h49
`define IO_READ_INSTRUCTION_RST_REG 8'h00
`define IO_READ_INSTRUCTION_TMR_W 12
`define IO_READ_INSTRUCTION_CLK_MHZ 250
`define IO_READ_INSTRUCTION_TMR_MHZ 1
`define IO_READ_INSTRUCTION_TMR_DIV (`IO_READ_INSTRUCTION_CLK_MHZ / `IO_READ_INSTRUCTION_TMR_MHZ)
`endif

// *** verilog/io_read_instruction_io_space.sv ***
// I/O register space: decode of read, direct write and indexed write
`timescale 1ns/1ps
`include "io_read_instruction_defines.svh"

//Contract
//- Read instruction returns addressed register contents into accumulator.
//- Direct write puts accumulator into register named by operand.
//- Indexed write address is operand plus index register.
//- Indexed write with operand zero selects register by index alone.
//- Vector register is read-only; reading it clears the pending interrupt.
//- Free-running 1 MHz timer readable as low byte and upper nibble.
//- Low byte read latches upper nibble; high register returns latched value.
//- Per-pin GPIO interrupt enable registers are write-only.
//- Each endpoint has byte count then mode register, both read-write.
//- Second function address unused in five-endpoint arrangement.
//- In five-endpoint arrangement second-address modes configure endpoints three, four.
//- Upstream USB status and control register is read-write.
//- Endpoint interrupt enable register is read-write, apart from global.
//- Hub port connect status register is read-write.
//- Hub port enable register is read-write.
module io_read_instruction_io_space
  import io_read_instruction_pkg::*;
#(
  parameter int TMR_DIV = `IO_READ_INSTRUCTION_TMR_DIV
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_io_read_instruction,
  input wire logic i_io_direct_write_instruction,
  input wire logic i_io_indexed_write_instruction,
  input wire logic [7:0] i_operand,
  input wire logic [7:0] i_index,
  input wire logic [7:0] i_acc,
  input wire logic i_five_ep_mode,
  input wire logic [7:0] i_irq_vector,
  output logic [7:0] o_acc_data,
  output logic o_acc_valid,
  output logic o_vector_clear,
  output logic o_watchdog_restart,
  output logic o_faddr_b_active,
  output logic [7:0] o_ep3_mode,
  output logic [7:0] o_ep4_mode,
  output logic [7:0] o_p0_irq_en,
  output logic [7:0] o_p1_irq_en,
  output logic [7:0] o_hub_en
);

  io_read_instruction_state_t s_q;
  io_read_instruction_state_t s_d;
  io_read_instruction_op_t op;
  logic [7:0] waddr;

  // Indexed address; operand zero leaves the index alone
  function automatic logic [7:0] idx_addr(input logic [7:0] opnd, input logic [7:0] x);
    idx_addr = 8'(opnd + x);
  endfunction : idx_addr

  always_comb begin
    if (i_io_read_instruction) begin
      op = IO_READ_INSTRUCTION_OP_READ;
    end else if (i_io_direct_write_instruction || i_io_indexed_write_instruction) begin
      op = IO_READ_INSTRUCTION_OP_WRITE;
    end else begin
      op = IO_READ_INSTRUCTION_OP_NONE;
    end
    if (i_io_indexed_write_instruction) begin
      waddr = idx_addr(i_operand, i_index);
    end else begin
      waddr = i_operand;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.vec_clr = 1'b0;
    s_d.wdog_restart = 1'b0;
    // Free-running timer at 1 MHz
    if (32'(s_q.tmr_pre) == TMR_DIV - 1) begin
      s_d.tmr_pre = 8'h00;
      s_d.tmr = 12'(s_q.tmr + 12'h001);
    end else begin
      s_d.tmr_pre = 8'(s_q.tmr_pre + 8'h01);
    end
    unique case (op)
      IO_READ_INSTRUCTION_OP_READ: begin
        s_d.rvalid = 1'b1;
        unique case (i_operand)
          `IO_READ_INSTRUCTION_A_P0_DATA: s_d.rdata = s_q.p0_data;
          `IO_READ_INSTRUCTION_A_P1_DATA: s_d.rdata = s_q.p1_data;
          `IO_READ_INSTRUCTION_A_GPIO_CFG: s_d.rdata = s_q.gpio_cfg;
          `IO_READ_INSTRUCTION_A_SB_POS_CFG: s_d.rdata = s_q.sb_pos_cfg;
          `IO_READ_INSTRUCTION_A_FADDR_A: s_d.rdata = s_q.faddr_a;
          `IO_READ_INSTRUCTION_A_A_EP0_CNT: s_d.rdata = s_q.a_ep0_cnt;
          `IO_READ_INSTRUCTION_A_A_EP0_MODE: s_d.rdata = s_q.a_ep0_mode;
          `IO_READ_INSTRUCTION_A_A_EP1_CNT: s_d.rdata = s_q.a_ep1_cnt;
          `IO_READ_INSTRUCTION_A_A_EP1_MODE: s_d.rdata = s_q.a_ep1_mode;
          `IO_READ_INSTRUCTION_A_A_EP2_CNT: s_d.rdata = s_q.a_ep2_cnt;
          `IO_READ_INSTRUCTION_A_A_EP2_MODE: s_d.rdata = s_q.a_ep2_mode;
          `IO_READ_INSTRUCTION_A_USB_STAT_CTL: s_d.rdata = s_q.usb_stat_ctl;
          `IO_READ_INSTRUCTION_A_GLB_IRQ_EN: s_d.rdata = s_q.glb_irq_en;
          `IO_READ_INSTRUCTION_A_EP_IRQ_EN: s_d.rdata = s_q.ep_irq_en;
          `IO_READ_INSTRUCTION_A_IRQ_VECTOR: begin
            s_d.rdata = i_irq_vector;
            s_d.vec_clr = 1'b1;
          end
          `IO_READ_INSTRUCTION_A_TMR_LO: begin
            s_d.rdata = s_q.tmr[7:0];
            s_d.tmr_hold = s_q.tmr[11:8];
          end
          `IO_READ_INSTRUCTION_A_TMR_HI: s_d.rdata = {4'h0, s_q.tmr_hold};
          `IO_READ_INSTRUCTION_A_SB_CTL_STAT: s_d.rdata = s_q.sb_ctl_stat;
          `IO_READ_INSTRUCTION_A_SB_DATA: s_d.rdata = s_q.sb_data;
          `IO_READ_INSTRUCTION_A_FADDR_B: s_d.rdata = s_q.faddr_b;
          `IO_READ_INSTRUCTION_A_B_EP0_CNT: s_d.rdata = s_q.b_ep0_cnt;
          `IO_READ_INSTRUCTION_A_B_EP0_MODE: s_d.rdata = s_q.b_ep0_mode;
          `IO_READ_INSTRUCTION_A_B_EP1_CNT: s_d.rdata = s_q.b_ep1_cnt;
          `IO_READ_INSTRUCTION_A_B_EP1_MODE: s_d.rdata = s_q.b_ep1_mode;
          `IO_READ_INSTRUCTION_A_HUB_CONN: s_d.rdata = s_q.hub_conn;
          `IO_READ_INSTRUCTION_A_HUB_EN: s_d.rdata = s_q.hub_en;
          default: s_d.rdata = 8'h00;
        endcase
      end
      IO_READ_INSTRUCTION_OP_WRITE: begin
        unique case (waddr)
          `IO_READ_INSTRUCTION_A_P0_DATA: s_d.p0_data = i_acc;
          `IO_READ_INSTRUCTION_A_P1_DATA: s_d.p1_data = i_acc;
          `IO_READ_INSTRUCTION_A_P0_IRQ_EN: s_d.p0_irq_en = i_acc;
          `IO_READ_INSTRUCTION_A_P1_IRQ_EN: s_d.p1_irq_en = i_acc;
          `IO_READ_INSTRUCTION_A_GPIO_CFG: s_d.gpio_cfg = i_acc;
          `IO_READ_INSTRUCTION_A_SB_POS_CFG: s_d.sb_pos_cfg = i_acc;
          `IO_READ_INSTRUCTION_A_FADDR_A: s_d.faddr_a = i_acc;
          `IO_READ_INSTRUCTION_A_A_EP0_CNT: s_d.a_ep0_cnt = i_acc;
          `IO_READ_INSTRUCTION_A_A_EP0_MODE: s_d.a_ep0_mode = i_acc;
          `IO_READ_INSTRUCTION_A_A_EP1_CNT: s_d.a_ep1_cnt = i_acc;
          `IO_READ_INSTRUCTION_A_A_EP1_MODE: s_d.a_ep1_mode = i_acc;
          `IO_READ_INSTRUCTION_A_A_EP2_CNT: s_d.a_ep2_cnt = i_acc;
          `IO_READ_INSTRUCTION_A_A_EP2_MODE: s_d.a_ep2_mode = i_acc;
          `IO_READ_INSTRUCTION_A_USB_STAT_CTL: s_d.usb_stat_ctl = i_acc;
          `IO_READ_INSTRUCTION_A_GLB_IRQ_EN: s_d.glb_irq_en = i_acc;
          `IO_READ_INSTRUCTION_A_EP_IRQ_EN: s_d.ep_irq_en = i_acc;
          `IO_READ_INSTRUCTION_A_WDOG_CLR: s_d.wdog_restart = 1'b1;
          `IO_READ_INSTRUCTION_A_SB_CTL_STAT: s_d.sb_ctl_stat = i_acc;
          `IO_READ_INSTRUCTION_A_SB_DATA: s_d.sb_data = i_acc;
          `IO_READ_INSTRUCTION_A_FADDR_B: s_d.faddr_b = i_acc;
          `IO_READ_INSTRUCTION_A_B_EP0_CNT: s_d.b_ep0_cnt = i_acc;
          `IO_READ_INSTRUCTION_A_B_EP0_MODE: s_d.b_ep0_mode = i_acc;
          `IO_READ_INSTRUCTION_A_B_EP1_CNT: s_d.b_ep1_cnt = i_acc;
          `IO_READ_INSTRUCTION_A_B_EP1_MODE: s_d.b_ep1_mode = i_acc;
          `IO_READ_INSTRUCTION_A_HUB_CONN: s_d.hub_conn = i_acc;
          `IO_READ_INSTRUCTION_A_HUB_EN: s_d.hub_en = i_acc;
          default: begin
          end
        endcase
      end
      IO_READ_INSTRUCTION_OP_NONE: begin
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Mode registers of the second address serve endpoints 3 and 4 in five-endpoint mode
  // Registered here so that every output leaves a flop
  logic fba_q;
  logic [7:0] ep3_q;
  logic [7:0] ep4_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fba_q <= 1'b1;
      ep3_q <= 8'h00;
      ep4_q <= 8'h00;
    end else begin
      fba_q <= ~i_five_ep_mode;
      ep3_q <= i_five_ep_mode ? s_q.b_ep0_mode : 8'h00;
      ep4_q <= i_five_ep_mode ? s_q.b_ep1_mode : 8'h00;
    end
  end

  assign o_acc_data = s_q.rdata;
  assign o_acc_valid = s_q.rvalid;
  assign o_vector_clear = s_q.vec_clr;
  assign o_watchdog_restart = s_q.wdog_restart;
  assign o_faddr_b_active = fba_q;
  assign o_ep3_mode = ep3_q;
  assign o_ep4_mode = ep4_q;
  assign o_p0_irq_en = s_q.p0_irq_en;
  assign o_p1_irq_en = s_q.p1_irq_en;
  assign o_hub_en = s_q.hub_en;

  property p_read_answer;
    @(posedge i_clk) disable iff (!i_rstn)
    i_io_read_instruction |=> o_acc_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_gpio_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_direct_write_instruction && !i_io_read_instruction
     && i_operand == `IO_READ_INSTRUCTION_A_P0_DATA) |=> (s_q.p0_data == $past(i_acc));
  endproperty
  a_gpio_write: assert property (p_gpio_write) else $error("direct write lost");

  property p_idx_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_indexed_write_instruction && !i_io_read_instruction
     && 8'(i_operand + i_index) == `IO_READ_INSTRUCTION_A_HUB_EN) |=> (o_hub_en == $past(i_acc));
  endproperty
  a_idx_write: assert property (p_idx_write) else $error("indexed write lost");

  property p_idx_zero;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_indexed_write_instruction && !i_io_read_instruction && i_operand == 8'h00
     && i_index == `IO_READ_INSTRUCTION_A_P1_IRQ_EN) |=> (o_p1_irq_en == $past(i_acc));
  endproperty
  a_idx_zero: assert property (p_idx_zero) else $error("zero operand index write");

  property p_vec_clear;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_read_instruction && i_operand == `IO_READ_INSTRUCTION_A_IRQ_VECTOR)
    |=> o_vector_clear && o_acc_data == $past(i_irq_vector);
  endproperty
  a_vec_clear: assert property (p_vec_clear) else $error("vector read no clear");

  sequence s_lo_read;
    i_io_read_instruction && i_operand == `IO_READ_INSTRUCTION_A_TMR_LO;
  endsequence

  sequence s_hi_read;
    i_io_read_instruction && i_operand == `IO_READ_INSTRUCTION_A_TMR_HI;
  endsequence

  property p_tmr_latch;
    @(posedge i_clk) disable iff (!i_rstn)
    s_lo_read ##1 s_hi_read
    |=> o_acc_data == {4'h0, $past(s_q.tmr[11:8], 2)};
  endproperty
  a_tmr_latch: assert property (p_tmr_latch) else $error("timer high not latched");

  property p_wo_read;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_read_instruction && i_operand == `IO_READ_INSTRUCTION_A_P0_IRQ_EN) |=> o_acc_data == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only reg readable");

  property p_unmapped;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_read_instruction && i_operand == 8'h30) |=> o_acc_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_five_map;
    @(posedge i_clk) disable iff (!i_rstn)
    i_five_ep_mode |=> (o_ep3_mode == $past(s_q.b_ep0_mode)
      && o_ep4_mode == $past(s_q.b_ep1_mode) && !o_faddr_b_active);
  endproperty
  a_five_map: assert property (p_five_map) else $error("five endpoint map wrong");

  property p_two_addr;
    @(posedge i_clk) disable iff (!i_rstn)
    !i_five_ep_mode |=> (o_faddr_b_active && o_ep3_mode == 8'h00 && o_ep4_mode == 8'h00);
  endproperty
  a_two_addr: assert property (p_two_addr) else $error("second address not active");

  property p_valid_pulse;
    @(posedge i_clk) disable iff (!i_rstn)
    !i_io_read_instruction |=> !o_acc_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid without read");

  property p_wdog_pulse;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_direct_write_instruction && !i_io_read_instruction
     && i_operand == `IO_READ_INSTRUCTION_A_WDOG_CLR) |=> o_watchdog_restart;
  endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("restart pulse missing");

  property p_usb_ctl;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_io_direct_write_instruction && !i_io_read_instruction
     && !i_io_indexed_write_instruction && i_operand == `IO_READ_INSTRUCTION_A_USB_STAT_CTL)
    |=> (s_q.usb_stat_ctl == $past(i_acc));
  endproperty
  a_usb_ctl: assert property (p_usb_ctl) else $error("upstream control write lost");

endmodule : io_read_instruction_io_space

// *** verilog/io_read_instruction_pkg.sv ***
// Types of the I/O register space decoder
package io_read_instruction_pkg;
  typedef enum logic [2:0] {
    IO_READ_INSTRUCTION_OP_NONE = 3'b001,
    IO_READ_INSTRUCTION_OP_READ = 3'b010,
    IO_READ_INSTRUCTION_OP_WRITE = 3'b100
  } io_read_instruction_op_t;
  typedef struct packed {
    logic [7:0] p0_data;
    logic [7:0] p1_data;
    logic [7:0] p0_irq_en;
    logic [7:0] p1_irq_en;
    logic [7:0] gpio_cfg;
    logic [7:0] sb_pos_cfg;
    logic [7:0] faddr_a;
    logic [7:0] a_ep0_cnt;
    logic [7:0] a_ep0_mode;
    logic [7:0] a_ep1_cnt;
    logic [7:0] a_ep1_mode;
    logic [7:0] a_ep2_cnt;
    logic [7:0] a_ep2_mode;
    logic [7:0] usb_stat_ctl;
    logic [7:0] glb_irq_en;
    logic [7:0] ep_irq_en;
    logic [7:0] sb_ctl_stat;
    logic [7:0] sb_data;
    logic [7:0] faddr_b;
    logic [7:0] b_ep0_cnt;
    logic [7:0] b_ep0_mode;
    logic [7:0] b_ep1_cnt;
    logic [7:0] b_ep1_mode;
    logic [7:0] hub_conn;
    logic [7:0] hub_en;
    logic [3:0] tmr_hold;
    logic [11:0] tmr;
    logic [7:0] tmr_pre;
    logic [7:0] rdata;
    logic rvalid;
    logic vec_clr;
    logic wdog_restart;
  } io_read_instruction_state_t;
endpackage : io_read_instruction_pkg
